// [hdl/disk_seq_pkg.sv]
// Constants, types and timing for the microsequencer decode block
package disk_seq_pkg;

   // ==========================================================
   // Clocking and machine-cycle timing
   localparam int CORE_HZ = 250_000_000;
   localparam int XTAL_HZ = 10_000_000;
   localparam int XTAL_DIV = CORE_HZ / XTAL_HZ;
   localparam int TICK_NS = 1_000_000_000 / XTAL_HZ;
   localparam int CYCLE_BASE_NS = 1600;
   localparam int CYCLE_FAST_NS = 1400;
   localparam int WRITE_WINDOW_NS = 500;
   localparam int CYCLE_BASE_TICKS = CYCLE_BASE_NS / TICK_NS;
   localparam int CYCLE_FAST_TICKS = CYCLE_FAST_NS / TICK_NS;
   localparam int WRITE_TICKS = WRITE_WINDOW_NS / TICK_NS;
   localparam logic [4:0] DIV_LAST = 5'(XTAL_DIV - 1);
   localparam logic [3:0] BASE_LAST = 4'(CYCLE_BASE_TICKS - 1);
   localparam logic [3:0] FAST_LAST = 4'(CYCLE_FAST_TICKS - 1);
   localparam logic [3:0] PH_FETCH = 4'h0;
   localparam logic [3:0] PH_WOPEN = 4'h3;
   localparam logic [3:0] PH_EXEC = 4'h4;
   // Window stays open through phase eight, so the address for a RAM write moves only as phase eight ends
   localparam logic [3:0] PH_UPDATE = 4'(int'(PH_WOPEN) + WRITE_TICKS);

   // ==========================================================
   // Register map and control bits
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_REGS = 8'h08;
   localparam logic [7:0] ADDR_INSN = 8'h0c;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_FAST = 1;
   localparam int CTRL_FORMAT = 2;
   localparam int CTRL_DOWN = 3;

   // ==========================================================
   // Microinstruction fields
   localparam int IR_TOP = 15;
   localparam int IR_IMMQ = 14;
   localparam int IR_DEST = 12;
   localparam int IR_SUB_HI = 11;
   localparam int IR_SUB_LO = 10;
   localparam int IR_RSEL = 8;
   localparam int IR_MODE = 4;
   localparam int IR_CUSE = 5;
   localparam logic [1:0] BR_JUMP = 2'h0;
   localparam logic [1:0] BR_UPPER = 2'h1;
   localparam logic [1:0] BR_LOWER = 2'h2;
   localparam logic [1:0] BR_COND = 2'h3;

   // ==========================================================
   // ALU function selects
   localparam logic [3:0] ALU_XOR = 4'h6;
   localparam logic [3:0] ALU_ADD = 4'h9;
   localparam logic [3:0] ALU_PASS_B = 4'ha;
   localparam logic [3:0] ALU_AND = 4'hb;
   localparam logic [3:0] ALU_OR = 4'he;

   typedef enum logic [0:0] {
      SEQ_HALT = 1'b0,
      SEQ_RUN = 1'b1
   } seq_state_type;

   typedef struct packed {
      logic immediate;
      logic control_cmd_decoded;
      logic reg_dest;
      logic unconditional_jump_decoded;
      logic mask_test_upper;
      logic mask_test_lower;
      logic long_branch_decoded;
      logic short_branch_decoded;
      logic cond_branch;
      logic ram_inhibit;
      logic logic_mode;
      logic carry_use;
      logic [3:0] alu_sel;
   } decode_type;

endpackage

// [hdl/seq_alu.sv]
// Eight-bit ALU with logic and arithmetic function sets
`timescale 1ns/1ns
module seq_alu (
   input wire logic logic_mode_i,
   input wire logic [3:0] sel_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic carry_i,
   output logic [7:0] f_o,
   output logic carry_o
);

   logic [7:0] x;
   logic [7:0] y;
   logic [7:0] lf;
   logic [8:0] sum;

   // ==========================================================
   // Function table, arithmetic is x plus y plus carry
   always_comb begin
      x = a_i;
      y = 8'h00;
      lf = a_i;
      case (sel_i)
         4'h0: begin lf = ~a_i; end
         4'h1: begin lf = ~(a_i | b_i); x = a_i | b_i; end
         4'h2: begin lf = ~a_i & b_i; x = a_i | ~b_i; end
         4'h3: begin lf = 8'h00; x = 8'h00; y = 8'hff; end
         4'h4: begin lf = ~(a_i & b_i); y = a_i & ~b_i; end
         4'h5: begin lf = ~b_i; x = a_i | b_i; y = a_i & ~b_i; end
         4'h6: begin lf = a_i ^ b_i; y = ~b_i; end
         4'h7: begin lf = a_i & ~b_i; x = a_i & ~b_i; y = 8'hff; end
         4'h8: begin lf = ~a_i | b_i; y = a_i & b_i; end
         4'h9: begin lf = ~(a_i ^ b_i); y = b_i; end
         4'ha: begin lf = b_i; x = a_i | ~b_i; y = a_i & b_i; end
         4'hb: begin lf = a_i & b_i; x = a_i & b_i; y = 8'hff; end
         4'hc: begin lf = 8'hff; y = a_i; end
         4'hd: begin lf = a_i | ~b_i; x = a_i | b_i; y = a_i; end
         4'he: begin lf = a_i | b_i; x = a_i | ~b_i; y = a_i; end
         default: begin lf = a_i; y = 8'hff; end
      endcase
   end

   // Mode high picks logic results, low picks arithmetic
   assign sum = {1'b0, x} + {1'b0, y} + {8'h00, carry_i};
   assign f_o = logic_mode_i ? lf : sum[7:0];
   assign carry_o = logic_mode_i ? 1'b0 : sum[8];

endmodule

// [hdl/disk_seq_decode.sv]
// Microinstruction decode, cycle timing and branch control with AHB-Lite registers
`timescale 1ns/1ns
module disk_seq_decode (
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic [15:0] ROM_WORD_I,
   input wire logic [7:0] RAM_DATA_I,
   input wire logic HOST_STROBE_I,
   input wire logic HOST_BUSY_I,
   input wire logic ADDR_XFER_I,
   input wire logic DATA_XFER_I,
   input wire logic REMOVABLE_SEL_I,
   input wire logic [3:0] DRIVE_STATUS_I,
   output logic FETCH_O,
   output logic ROM_ADVANCE_O,
   output logic [9:0] RAM_ADDR_O,
   output logic [7:0] RAM_WDATA_O,
   output logic RAM_WRITE_O,
   output logic BRANCH_LOAD_LOW_O,
   output logic BRANCH_LOAD_HIGH_O,
   output logic JUMP_O,
   output logic [9:0] BRANCH_TARGET_O,
   output logic SHORT_BRANCH_O,
   output logic LONG_BRANCH_O,
   output logic CONTROL_CMD_O
);

   // ==========================================================
   // Declarations
   logic [3:0] ctrl;
   disk_seq_pkg::seq_state_type state;
   logic [4:0] div_cnt;
   logic [3:0] phase;
   logic [15:0] ir;
   logic [7:0] ram_word;
   disk_seq_pkg::decode_type dec;
   disk_seq_pkg::decode_type next_dec;
   logic [7:0] regs [0:3];
   logic carry;
   logic [9:0] ram_addr;
   logic [8:0] sync1;
   logic [8:0] sync2;
   logic ph_valid;
   logic ahb_wr;
   logic [7:0] ahb_addr;

   wire tick = (div_cnt == disk_seq_pkg::DIV_LAST);
   wire running = (state == disk_seq_pkg::SEQ_RUN);
   wire [3:0] last_phase = ctrl[disk_seq_pkg::CTRL_FAST] ? disk_seq_pkg::FAST_LAST
                                                         : disk_seq_pkg::BASE_LAST;
   wire phase_fetch = tick & ctrl[disk_seq_pkg::CTRL_RUN] & (phase == disk_seq_pkg::PH_FETCH);
   wire phase_write_open = tick & running & (phase == disk_seq_pkg::PH_WOPEN);
   wire phase_execute = tick & running & (phase == disk_seq_pkg::PH_EXEC);
   wire phase_address_update = tick & running & (phase == disk_seq_pkg::PH_UPDATE);
   wire phase_write_close = phase_address_update;

   // ==========================================================
   // Instruction class decode from the ROM word
   wire [15:0] w = ROM_WORD_I;
   wire imm_like = w[disk_seq_pkg::IR_TOP] & w[disk_seq_pkg::IR_IMMQ] & w[disk_seq_pkg::IR_SUB_HI];
   wire br_class = w[disk_seq_pkg::IR_TOP] & ~w[disk_seq_pkg::IR_IMMQ];
   wire reg_class = ~w[disk_seq_pkg::IR_TOP];
   wire [1:0] br_kind = w[disk_seq_pkg::IR_SUB_HI:disk_seq_pkg::IR_SUB_LO];
   wire [1:0] imm_op = w[13:12];
   wire imm_is = imm_like & ~w[disk_seq_pkg::IR_SUB_LO];
   wire ctl_is = imm_like & w[disk_seq_pkg::IR_SUB_LO];
   wire jump_is = br_class & (br_kind == disk_seq_pkg::BR_JUMP);
   wire cond_is = br_class & (br_kind == disk_seq_pkg::BR_COND);
   wire rdest_is = reg_class & w[disk_seq_pkg::IR_DEST];
   wire [3:0] imm_sel = (imm_op == 2'h0) ? disk_seq_pkg::ALU_PASS_B :
                        (imm_op == 2'h1) ? disk_seq_pkg::ALU_ADD :
                        (imm_op == 2'h2) ? disk_seq_pkg::ALU_AND : disk_seq_pkg::ALU_OR;

   // Mode and select chosen by class; control command steers the function decoder
   always_comb begin
      next_dec.immediate = imm_is;
      next_dec.control_cmd_decoded = ctl_is;
      next_dec.reg_dest = rdest_is;
      next_dec.unconditional_jump_decoded = jump_is;
      next_dec.mask_test_upper = br_class & (br_kind == disk_seq_pkg::BR_UPPER);
      next_dec.mask_test_lower = br_class & (br_kind == disk_seq_pkg::BR_LOWER);
      next_dec.long_branch_decoded = jump_is | cond_is;
      next_dec.short_branch_decoded = br_class;
      next_dec.cond_branch = cond_is;
      next_dec.ram_inhibit = ~(reg_class & ~w[disk_seq_pkg::IR_DEST]);
      next_dec.carry_use = reg_class & w[disk_seq_pkg::IR_CUSE];
      if (reg_class) begin
         next_dec.logic_mode = w[disk_seq_pkg::IR_MODE];
         next_dec.alu_sel = w[3:0];
      end else if (ctl_is) begin
         next_dec.logic_mode = 1'b1;
         next_dec.alu_sel = disk_seq_pkg::ALU_PASS_B;
      end else if (imm_is) begin
         next_dec.logic_mode = (imm_sel != disk_seq_pkg::ALU_ADD);
         next_dec.alu_sel = imm_sel;
      end else begin
         next_dec.logic_mode = 1'b1;
         next_dec.alu_sel = disk_seq_pkg::ALU_XOR;
      end
   end

   // ==========================================================
   // Operand selection and ALU
   wire [1:0] rsel = ir[disk_seq_pkg::IR_RSEL +: 2];
   wire [7:0] reg_sel = regs[rsel];
   wire [3:0] mask = ir[3:0];
   wire [7:0] a_bus = dec.mask_test_upper ? {reg_sel[7:4], 4'h0} :
                      dec.mask_test_lower ? {4'h0, reg_sel[3:0]} : reg_sel;
   wire [7:0] operand_bus_lines = (dec.immediate | dec.control_cmd_decoded) ? ir[7:0] :
                                  dec.mask_test_upper ? {mask, 4'h0} :
                                  dec.mask_test_lower ? {4'h0, mask} : ram_word;
   wire [7:0] alu_f;
   wire alu_cout;
   wire taken = dec.unconditional_jump_decoded | (dec.cond_branch & (reg_sel != 8'h00)) |
                ((dec.mask_test_upper | dec.mask_test_lower) & (alu_f == 8'h00));
   wire strobe_reg = dec.reg_dest | dec.immediate;
   wire ram_write_permit = ~dec.ram_inhibit;

   seq_alu alu (
      .logic_mode_i(dec.logic_mode),
      .sel_i(dec.alu_sel),
      .a_i(a_bus),
      .b_i(operand_bus_lines),
      .carry_i(dec.carry_use & carry),
      .f_o(alu_f),
      .carry_o(alu_cout)
   );

   // ==========================================================
   // Status synchroniser, gating per transfer type
   wire [8:0] raw_in = {REMOVABLE_SEL_I, DRIVE_STATUS_I, DATA_XFER_I, ADDR_XFER_I,
                        HOST_BUSY_I, HOST_STROBE_I};
   wire s_strobe = sync2[0];
   wire s_busy = sync2[1];
   wire s_addr = sync2[2];
   wire s_data = sync2[3];
   wire [3:0] s_drive = sync2[7:4];
   wire s_removable = sync2[8];
   wire strobe_gated = s_strobe & (s_addr | s_data);
   wire busy_gated = s_busy & s_data;
   wire [7:0] status_word = {s_drive, busy_gated, strobe_gated, s_addr, s_data};

   // Two-stage synchroniser for pin inputs
   always_ff @(posedge CORE_CLK_I) begin
      sync1 <= raw_in;
      sync2 <= sync1;
   end

   // ==========================================================
   // Time base: 10 MHz tick from the core clock, then cycle phases
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || tick) begin
         div_cnt <= 5'h00;
      end else begin
         div_cnt <= div_cnt + 5'h01;
      end
   end

   // Phase counter wraps at 16 or 14 ticks; halts at fetch when stopped
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         phase <= disk_seq_pkg::PH_FETCH;
         state <= disk_seq_pkg::SEQ_HALT;
      end else if (tick) begin
         if (phase == disk_seq_pkg::PH_FETCH) begin
            state <= ctrl[disk_seq_pkg::CTRL_RUN] ? disk_seq_pkg::SEQ_RUN : disk_seq_pkg::SEQ_HALT;
            phase <= ctrl[disk_seq_pkg::CTRL_RUN] ? 4'h1 : disk_seq_pkg::PH_FETCH;
         end else if (phase >= last_phase) begin
            phase <= disk_seq_pkg::PH_FETCH;
         end else begin
            phase <= phase + 4'h1;
         end
      end
   end

   // ==========================================================
   // Fetch: latch RAM word, microinstruction and decode
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         ir <= 16'h0000;
         ram_word <= 8'h00;
         dec <= '0;
      end else if (phase_fetch) begin
         ir <= ROM_WORD_I;
         ram_word <= RAM_DATA_I;
         dec <= next_dec;
      end
   end

   // Registers: status loads at fetch, selected register clocked at execute
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         regs[0] <= 8'h00;
         regs[1] <= 8'h00;
         regs[2] <= 8'h00;
         regs[3] <= 8'h00;
      end else if (phase_execute && strobe_reg) begin
         regs[rsel] <= alu_f;
      end else if (phase_fetch) begin
         regs[0] <= status_word;
      end
   end

   // Carry: ALU carry normally, drive indicator while formatting
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         carry <= 1'b0;
      end else if (ctrl[disk_seq_pkg::CTRL_FORMAT]) begin
         carry <= s_removable;
      end else if (phase_execute && !dec.logic_mode && (strobe_reg || ram_write_permit)) begin
         carry <= alu_cout;
      end
   end

   // RAM address: step at execute for register-destination results (not immediates), at update for RAM writes
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         ram_addr <= 10'h000;
      end else if (phase_execute && dec.reg_dest) begin
         ram_addr <= ram_addr + 10'h001;
      end else if (phase_address_update && ram_write_permit) begin
         ram_addr <= ctrl[disk_seq_pkg::CTRL_DOWN] ? ram_addr - 10'h001
                                                  : ram_addr + 10'h001;
      end
   end

   // ==========================================================
   // Registered outputs toward ROM, RAM and host boards
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         FETCH_O <= 1'b0;
         ROM_ADVANCE_O <= 1'b0;
         RAM_WRITE_O <= 1'b0;
         RAM_WDATA_O <= 8'h00;
      end else begin
         FETCH_O <= phase_fetch;
         ROM_ADVANCE_O <= phase_execute & ~taken;
         if (phase_write_open) begin
            RAM_WRITE_O <= ram_write_permit;
         end else if (phase_write_close) begin
            RAM_WRITE_O <= 1'b0;
         end
         if (phase_execute) begin
            RAM_WDATA_O <= alu_f;
         end
      end
   end

   // Branch loads at execute, cleared at next fetch; decode flags follow the latch
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I || phase_fetch) begin
         BRANCH_LOAD_LOW_O <= 1'b0;
         BRANCH_LOAD_HIGH_O <= 1'b0;
         JUMP_O <= 1'b0;
      end else if (phase_execute) begin
         BRANCH_LOAD_LOW_O <= dec.short_branch_decoded & taken;
         BRANCH_LOAD_HIGH_O <= dec.long_branch_decoded & taken;
         JUMP_O <= dec.unconditional_jump_decoded;
      end
   end

   // Decode flags to the pins, one cycle behind the fetch latch
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         SHORT_BRANCH_O <= 1'b0;
         LONG_BRANCH_O <= 1'b0;
         CONTROL_CMD_O <= 1'b0;
         BRANCH_TARGET_O <= 10'h000;
         RAM_ADDR_O <= 10'h000;
      end else begin
         SHORT_BRANCH_O <= dec.short_branch_decoded;
         LONG_BRANCH_O <= dec.long_branch_decoded;
         CONTROL_CMD_O <= dec.control_cmd_decoded;
         BRANCH_TARGET_O <= {ir[13:12], ir[7:0]};
         RAM_ADDR_O <= ram_addr;
      end
   end

   // ==========================================================
   // AHB-Lite slave: zero wait states, always OKAY
   wire ahb_take = HSEL_I & HTRANS_I[1] & HREADY_I;
   wire [7:0] a_off = HADDR_I[7:0];
   wire [31:0] stat_word = {11'h000, carry, phase, 6'h00, ram_addr};
   wire [31:0] regs_word = {regs[3], regs[2], regs[1], regs[0]};
   wire [31:0] rd_mux = (a_off == disk_seq_pkg::ADDR_CTRL) ? {28'h0000000, ctrl} :
                        (a_off == disk_seq_pkg::ADDR_STAT) ? stat_word :
                        (a_off == disk_seq_pkg::ADDR_REGS) ? regs_word :
                        (a_off == disk_seq_pkg::ADDR_INSN) ? {16'h0000, ir} : 32'h00000000;

   // Address phase capture and read data register
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         ahb_wr <= 1'b0;
         ahb_addr <= 8'h00;
         HRDATA_O <= 32'h00000000;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
      end else begin
         ahb_wr <= ahb_take & HWRITE_I;
         ahb_addr <= a_off;
         HREADYOUT_O <= 1'b1;
         HRESP_O <= 1'b0;
         if (ahb_take && !HWRITE_I) begin
            HRDATA_O <= rd_mux;
         end
      end
   end

   // Control register written in the data phase
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         ctrl <= disk_seq_pkg::CTRL_RESET;
      end else if (ahb_wr && ahb_addr == disk_seq_pkg::ADDR_CTRL) begin
         ctrl <= HWDATA_I[3:0];
      end
   end

endmodule

// [bench/disk_seq_decode_asserts.sv]
// Checker of cycle timing and branch decode relations at the decode block's ports
`timescale 1ns/1ns
module disk_seq_decode_asserts (
   input wire logic CORE_CLK_I,
   input wire logic RESET_I,
   input wire logic FETCH_O,
   input wire logic ROM_ADVANCE_O,
   input wire logic [9:0] RAM_ADDR_O,
   input wire logic RAM_WRITE_O,
   input wire logic BRANCH_LOAD_LOW_O,
   input wire logic BRANCH_LOAD_HIGH_O,
   input wire logic JUMP_O,
   input wire logic SHORT_BRANCH_O,
   input wire logic LONG_BRANCH_O,
   input wire logic CONTROL_CMD_O
);
   logic [15:0] cnt;
   logic [7:0] wcnt;
   logic seen;
   // ==========================================================
   // Clocks since the last fetch and length of the write window
   always_ff @(posedge CORE_CLK_I) begin
      if (RESET_I) begin
         cnt <= 16'h0000;
         wcnt <= 8'h00;
         seen <= 1'b0;
      end else begin
         cnt <= FETCH_O ? 16'h0001 : cnt + 16'(cnt != 16'hffff);
         wcnt <= RAM_WRITE_O ? wcnt + 8'h01 : 8'h00;
         seen <= seen | FETCH_O;
      end
   end
   // ==========================================================
   // Properties
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (RESET_I);
   sequence s_win_open; $rose(RAM_WRITE_O); endsequence
   sequence s_win_close; $fell(RAM_WRITE_O); endsequence
   property p_win_open; s_win_open |-> cnt == 16'h004b; endproperty
   property p_win_len; s_win_close |-> wcnt == 8'h7d; endproperty
   property p_exec; ROM_ADVANCE_O |-> cnt == 16'h0064 && !BRANCH_LOAD_LOW_O; endproperty
   property p_addr; $changed(RAM_ADDR_O) |-> cnt == 16'h0065 || cnt == 16'h00c9; endproperty
   property p_cycle; FETCH_O && seen |-> cnt >= 16'h015e; endproperty
   property p_stable; $changed({SHORT_BRANCH_O, LONG_BRANCH_O, CONTROL_CMD_O}) |-> $past(FETCH_O); endproperty
   property p_len; LONG_BRANCH_O |-> SHORT_BRANCH_O; endproperty
   property p_loads; BRANCH_LOAD_HIGH_O |-> BRANCH_LOAD_LOW_O; endproperty
   property p_jump; JUMP_O |-> BRANCH_LOAD_HIGH_O && BRANCH_LOAD_LOW_O; endproperty
   property p_ccmd; CONTROL_CMD_O |-> !SHORT_BRANCH_O && !LONG_BRANCH_O; endproperty
   a_win_open: assert property (p_win_open) else $error("write window opened off phase");
   a_win_len: assert property (p_win_len) else $error("write window length wrong");
   a_exec: assert property (p_exec) else $error("advance off execute phase");
   a_addr: assert property (p_addr) else $error("ram address moved off phase");
   a_cycle: assert property (p_cycle) else $error("machine cycle too short");
   a_stable: assert property (p_stable) else $error("decode changed mid cycle");
   a_len: assert property (p_len) else $error("long branch without short");
   a_loads: assert property (p_loads) else $error("high load without low");
   a_jump: assert property (p_jump) else $error("jump without both loads");
   a_ccmd: assert property (p_ccmd) else $error("control command seen as branch");
endmodule
bind disk_seq_decode disk_seq_decode_asserts u_chk (.CORE_CLK_I, .RESET_I, .FETCH_O, .ROM_ADVANCE_O,
   .RAM_ADDR_O, .RAM_WRITE_O, .BRANCH_LOAD_LOW_O, .BRANCH_LOAD_HIGH_O, .JUMP_O, .SHORT_BRANCH_O,
   .LONG_BRANCH_O, .CONTROL_CMD_O);

// [bench/disk_seq_partner.sv]
// Microprogram store and working memory on the far side of the decode block
`timescale 1ns/1ns
module disk_seq_partner (
   input wire logic clk_i,
   input wire logic rom_advance_i,
   input wire logic load_low_i,
   input wire logic load_high_i,
   input wire logic [9:0] target_i,
   input wire logic [9:0] ram_addr_i,
   input wire logic [7:0] ram_wdata_i,
   input wire logic ram_write_i,
   output logic [15:0] rom_word_o,
   output logic [7:0] ram_data_o
);
   logic [9:0] pc = 10'h000;
   logic last_load = 1'b0;
   logic [7:0] mem [0:1023];
   logic [15:0] prog [0:15] = '{16'hc95a, 16'he90f, 16'hf9a0, 16'h1116, 16'h1203, 16'hcb77, 16'h1313,
      16'h1209, 16'h0116, 16'h800c, 16'h8020, 16'h8d20, 16'hcc00, 16'h850b, 16'hcb33, 16'h8020};
   // ==========================================================
   // Word at the program counter and at the memory address
   assign rom_word_o = (pc < 10'h010) ? prog[pc[3:0]] : 16'h8020;
   assign ram_data_o = mem[ram_addr_i];
   // Memory starts with a known pattern
   initial begin
      for (int i = 0; i < 1024; i++) mem[i] = 8'(i) + 8'h11;
   end
   // Counter steps, loads a nibble or a whole target, and memory takes writes
   always @(posedge clk_i) begin
      last_load <= load_low_i;
      if (ram_write_i) mem[ram_addr_i] <= ram_wdata_i;
      if (load_low_i && !last_load) pc <= load_high_i ? target_i : {pc[9:4], target_i[3:0]};
      else if (rom_advance_i) pc <= pc + 10'h001;
   end
endmodule

// [bench/disk_seq_decode_tb_top.sv]
// Self-checking bench: register access and a short microprogram through the decode block
`timescale 1ns/1ns
module disk_seq_decode_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hwrite = 1'b0, strobe = 1'b1, busy = 1'b1, axfer = 1'b0, dxfer = 1'b1, remov = 1'b0;
   logic [3:0] drive = 4'h5;
   logic [15:0] rom_word;
   logic [7:0] ram_data, wdata;
   logic [9:0] raddr, target;
   logic hready, hresp, fetch, adv, rwrite, ld_lo, ld_hi, jump, shortb, longb, ccmd;
   int error_cnt = 0, checks = 0, cyc = 0, per = 0;
   // ==========================================================
   // Clock, design and far side
   always #2 clk = ~clk;
   disk_seq_decode dut (.CORE_CLK_I(clk), .RESET_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .ROM_WORD_I(rom_word), .RAM_DATA_I(ram_data),
      .HOST_STROBE_I(strobe), .HOST_BUSY_I(busy), .ADDR_XFER_I(axfer), .DATA_XFER_I(dxfer),
      .REMOVABLE_SEL_I(remov), .DRIVE_STATUS_I(drive), .FETCH_O(fetch), .ROM_ADVANCE_O(adv),
      .RAM_ADDR_O(raddr), .RAM_WDATA_O(wdata), .RAM_WRITE_O(rwrite), .BRANCH_LOAD_LOW_O(ld_lo),
      .BRANCH_LOAD_HIGH_O(ld_hi), .JUMP_O(jump), .BRANCH_TARGET_O(target), .SHORT_BRANCH_O(shortb),
      .LONG_BRANCH_O(longb), .CONTROL_CMD_O(ccmd));
   disk_seq_partner u_far (.clk_i(clk), .rom_advance_i(adv), .load_low_i(ld_lo), .load_high_i(ld_hi),
      .target_i(target), .ram_addr_i(raddr), .ram_wdata_i(wdata), .ram_write_i(rwrite),
      .rom_word_o(rom_word), .ram_data_o(ram_data));
   // ==========================================================
   // Verdict and timeout
   task automatic complete_run();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         complete_run();
      end
   end
   // ==========================================================
   // Bus tasks and comparison
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // One single transfer, write or read
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Read and compare under a mask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      xfer(1'b0, a, 32'h0);
      chk(n, e & m, rd & m);
   endtask
   // Clocks from one fetch pulse to the next
   task automatic period();
      @(posedge clk iff fetch === 1'b1);
      per = 0;
      do begin
         @(posedge clk);
         per++;
      end while (fetch !== 1'b1);
   endtask
   // ==========================================================
   // Test sequence
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 5; i++) rchk(8'(4 * i), 32'hfff0ffff, 32'h0, "reset value");
      chk("bus idle", 32'h2, {30'h0, hready, hresp});
      $display("test reset done");
      xfer(1'b1, 8'h00, 32'h1);
      rchk(8'h00, 32'hffffffff, 32'h1, "ctrl");
      do xfer(1'b0, 8'h0c, 32'h0); while (rd[15:0] !== 16'h8020);
      rchk(8'h08, 32'hffffff00, 32'h0013bb00, "regs");
      rchk(8'h08, 32'h000000ff, 32'h0000005d, "status reg");
      rchk(8'h04, 32'h001003ff, 32'h00100005, "stat");
      chk("ram 4", 32'hae, {24'h0, u_far.mem[4]});
      chk("ram 3", 32'h14, {24'h0, u_far.mem[3]});
      $display("test program done");
      period();
      chk("base cycle", 32'h190, 32'(per));
      xfer(1'b1, 8'h00, 32'h3);
      period();
      period();
      chk("fast cycle", 32'h15e, 32'(per));
      $display("test timing done");
      xfer(1'b1, 8'h00, 32'h5);
      xfer(1'b0, 8'h04, 32'h0);
      rchk(8'h04, 32'h00100000, 32'h0, "fixed drive");
      remov <= 1'b1;
      xfer(1'b0, 8'h04, 32'h0);
      rchk(8'h04, 32'h00100000, 32'h00100000, "removable drive");
      $display("test format done");
      complete_run();
   end
endmodule
